// file: hw/uart_bg_params.svh
// register indices, field positions, reset values and bit timing counts
`ifndef UART_BG_PARAMS_SVH
`define UART_BG_PARAMS_SVH
// register indices; byte address is four times the index
`define IDX_CFG 18'h0ff70
`define IDX_ERR 18'h0ff71
`define IDX_BSS 18'h0ff73
`define IDX_TXD 18'h0ff74
`define IDX_RXD 18'h0ff75
`define IDX_ISR 18'h0ff76
`define IDX_IMR 18'h0ff77
// reset values
`define BSS_RESET 8'h00
`define CFG_RESET 6'h00
`define IRQ_RESET 3'h0
// source selector codes
`define SEL_INT_MAX 4'h7
`define SEL_EXT 4'h8
// source ticks per bit, and the tick that marks mid start bit
`define TICK_LAST 4'hf
`define TICK_HALF 4'h7
// interrupt bit positions
`define EV_TX_DONE 0
`define EV_RX_DONE 1
`define EV_RX_ERR 2
// bus answers
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11
`endif

// file: hw/uart_bg_pkg.sv
// types shared by the baud generator and framing logic
package uart_bg_pkg;
  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_ZERO = 2'b01,
    PAR_ODD = 2'b10,
    PAR_EVEN = 2'b11
  } parity_mode_t;
  typedef struct packed {
    logic tx_en;
    logic rx_en;
    parity_mode_t parity;
    logic char_len_sel;
    logic stop_len_sel;
  } async_frame_config_t;
  typedef struct packed {
    logic pe;
    logic fe;
    logic ove;
  } rx_error_status_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b011,
    ST_PAR = 3'b010,
    ST_STOP = 3'b110
  } frame_state_t;
endpackage

// file: hw/uart_baud_framing.sv
// baud generator and async framing with an axi4-lite register slave
// How it works
// R1: source select byte, resets zero, low nibble zero
// R2: codes 0..7 pick clock over 2^(code+1)
// R3: internal bit rate is source over sixteen
// R4: code 8 uses external pin over sixteen
// R5: software avoids selector writes mid transfer
// R6: software avoids fast selectors at high clocks
// R7: software sets external pin as input
// R8: start, 7/8 bits, parity, 1/2 stops
// R9: 7-bit mode drops and zeroes bit 7
// R10: even parity bit makes ones count even
// R11: zero and no parity never flag errors
// R12: receive error cause readable in status
// R13: parity, length and stop field encodings
// R14: receiver checks only the first stop
// R15: even parity rx errors on odd count
// R16: odd parity bit makes ones count odd
// R17: sixteen ticks per bit, sample at midpoint
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "uart_bg_params.svh"
module uart_baud_framing
  import uart_bg_pkg::*;
(
  input wire logic CLK, // 40 mhz system clock
  input wire logic SYS_RST, // synchronous reset, active high
  input wire logic [19:0] AWADDR, // write byte address
  input wire logic AWVALID, // write address valid
  output logic AWREADY, // write address ready
  input wire logic [31:0] WDATA, // write data
  input wire logic [3:0] WSTRB, // write byte strobes
  input wire logic WVALID, // write data valid
  output logic WREADY, // write data ready
  output logic [1:0] BRESP, // write response
  output logic BVALID, // write response valid
  input wire logic BREADY, // write response ready
  input wire logic [19:0] ARADDR, // read byte address
  input wire logic ARVALID, // read address valid
  output logic ARREADY, // read address ready
  output logic [31:0] RDATA, // read data
  output logic [1:0] RRESP, // read response
  output logic RVALID, // read data valid
  input wire logic RREADY, // read data ready
  output logic TXD, // serial transmit line
  input wire logic RXD, // serial receive line
  input wire logic EXT_BIT_CLK, // external bit clock input
  output logic IRQ // level interrupt
);

  // ****************************************
  // register bus
  // ****************************************
  logic aw_held;
  logic w_held;
  logic [17:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;

  // address and data are taken in either order, one write at a time
  assign AWREADY = !aw_held && !bvalid;
  assign WREADY = !w_held && !bvalid;
  assign ARREADY = !rvalid;
  assign BVALID = bvalid;
  assign BRESP = bresp;
  assign RVALID = rvalid;
  assign RDATA = rdata;
  assign RRESP = rresp;

  wire aw_take = AWVALID && AWREADY;
  wire w_take = WVALID && WREADY;
  wire wr_go = aw_held && w_held;
  wire ar_take = ARVALID && ARREADY;
  wire [17:0] ar_idx = ARADDR[19:2];
  wire lane0 = w_strb[0];

  // write decode
  wire wr_cfg = wr_go && aw_idx == `IDX_CFG && lane0;
  wire wr_bss = wr_go && aw_idx == `IDX_BSS && lane0;
  wire wr_txd = wr_go && aw_idx == `IDX_TXD && lane0;
  wire wr_isr = wr_go && aw_idx == `IDX_ISR && lane0;
  wire wr_imr = wr_go && aw_idx == `IDX_IMR && lane0;
  wire wr_hit = aw_idx == `IDX_CFG || aw_idx == `IDX_ERR ||
                aw_idx == `IDX_BSS || aw_idx == `IDX_TXD ||
                aw_idx == `IDX_RXD || aw_idx == `IDX_ISR ||
                aw_idx == `IDX_IMR;

  // write channel holding and response
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 18'h00000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_idx <= AWADDR[19:2];
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
      end else if (bvalid && BREADY) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // control and status registers
  // ****************************************
  logic [7:0] baud_source_select;
  async_frame_config_t cfg;
  rx_error_status_t rx_error_status;
  logic [7:0] rx_data;
  logic rx_full;
  logic [2:0] int_status;
  logic [2:0] int_mask;
  logic tx_busy;

  // selector takes full-word writes only (all four strobes), low nibble stays zero
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      baud_source_select <= `BSS_RESET; // see R1
      cfg <= async_frame_config_t'(`CFG_RESET);
      int_mask <= `IRQ_RESET;
    end else begin
      if (wr_bss && w_strb == 4'hf) begin
        baud_source_select <= {w_data[7:4], 4'h0}; // see R1
      end
      if (wr_cfg) begin
        cfg <= async_frame_config_t'(w_data[7:2]); // see R13
      end
      if (wr_imr) begin
        int_mask <= w_data[2:0];
      end
    end
  end

  // read mux; bits above each register read zero
  wire rd_hit = ar_idx == `IDX_CFG || ar_idx == `IDX_ERR ||
                ar_idx == `IDX_BSS || ar_idx == `IDX_TXD ||
                ar_idx == `IDX_RXD || ar_idx == `IDX_ISR ||
                ar_idx == `IDX_IMR;
  wire [31:0] rd_mux =
    ar_idx == `IDX_CFG ? {24'h000000, cfg, 2'b00} :
    ar_idx == `IDX_ERR ? {29'h00000000, rx_error_status} : // see R12
    ar_idx == `IDX_BSS ? {24'h000000, baud_source_select} :
    ar_idx == `IDX_TXD ? {31'h00000000, tx_busy} :
    ar_idx == `IDX_RXD ? {24'h000000, rx_data} :
    ar_idx == `IDX_ISR ? {29'h00000000, int_status} :
    ar_idx == `IDX_IMR ? {29'h00000000, int_mask} : 32'h00000000;
  // reading the receive buffer frees it and clears the error cause
  wire rd_rxd = ar_take && ar_idx == `IDX_RXD;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
    end else if (rvalid && RREADY) begin
      rvalid <= 1'b0;
    end
  end

  // ****************************************
  // baud tick generator
  // ****************************************
  logic [7:0] div_cnt;
  logic ext_q;
  wire [3:0] sel = baud_source_select[7:4];
  // code k divides by 2^(k+1); prohibited codes give no tick at all
  wire [8:0] div_mask9 = (9'h002 << sel[2:0]) - 9'h001; // see R2
  wire [7:0] div_mask = div_mask9[7:0];
  wire int_tick = (div_cnt & div_mask) == div_mask;
  wire ext_tick = EXT_BIT_CLK && !ext_q;
  // one tick per source clock; a bit is sixteen ticks
  wire tick = sel <= `SEL_INT_MAX ? int_tick : // see R3
              sel == `SEL_EXT ? ext_tick : 1'b0; // see R4

  // free running divider; a selector write mid frame shifts phase
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      div_cnt <= 8'h00;
      ext_q <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      ext_q <= EXT_BIT_CLK; // see R7
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  frame_state_t tx_state;
  logic [3:0] tx_ticks;
  logic [2:0] tx_bit;
  logic [7:0] tx_shift;
  logic tx_par;
  logic tx_stop2;
  logic txd_q;
  logic tx_done;

  // seven-bit mode drops data bit 7 before parity and shifting
  wire [7:0] tx_word = cfg.char_len_sel ? w_data[7:0] :
                       {1'b0, w_data[6:0]}; // see R9
  wire tx_ones = ^tx_word;
  wire tx_par_bit = cfg.parity == PAR_EVEN ? tx_ones : // see R10
                    cfg.parity == PAR_ODD ? !tx_ones : 1'b0; // see R16
  wire [2:0] last_bit = cfg.char_len_sel ? 3'h7 : 3'h6;
  wire tx_end = tick && tx_ticks == `TICK_LAST; // see R17
  wire tx_load = wr_txd && cfg.tx_en && tx_state == ST_IDLE;
  assign tx_busy = tx_state != ST_IDLE;

  // frame sequence: start, data lsb first, parity, stops
  always_ff @(posedge CLK) begin
    if (SYS_RST || !cfg.tx_en) begin
      tx_state <= ST_IDLE;
      tx_ticks <= 4'h0;
      tx_bit <= 3'h0;
      tx_shift <= 8'h00;
      tx_par <= 1'b0;
      tx_stop2 <= 1'b0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (tick) begin
        tx_ticks <= tx_ticks + 4'h1;
      end
      case (tx_state)
        ST_IDLE: begin
          tx_ticks <= 4'h0;
          if (tx_load) begin
            tx_shift <= tx_word;
            tx_par <= tx_par_bit;
            tx_stop2 <= 1'b0;
            tx_state <= ST_START; // see R8
          end
        end
        ST_START: begin
          if (tx_end) begin
            tx_bit <= 3'h0;
            tx_state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tx_end) begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit == last_bit) begin
              tx_state <= cfg.parity == PAR_NONE ? ST_STOP : ST_PAR;
            end
          end
        end
        ST_PAR: begin
          if (tx_end) begin
            tx_state <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tx_end) begin
            if (cfg.stop_len_sel && !tx_stop2) begin
              tx_stop2 <= 1'b1; // see R8
            end else begin
              tx_done <= 1'b1;
              tx_state <= ST_IDLE;
            end
          end
        end
        default: tx_state <= ST_IDLE;
      endcase
    end
  end

  // line level registered, so it lags the state by one clock
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      txd_q <= 1'b1;
    end else begin
      txd_q <= tx_state == ST_START ? 1'b0 :
               tx_state == ST_DATA ? tx_shift[0] :
               tx_state == ST_PAR ? tx_par : 1'b1;
    end
  end
  assign TXD = txd_q;

  // ****************************************
  // receiver
  // ****************************************
  frame_state_t rx_state;
  logic [3:0] rx_ticks;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic rx_pbit;
  logic rx_done;
  logic rx_err_ev;

  wire rx_mid = tick && rx_ticks == `TICK_LAST; // see R17
  wire rx_ones = ^rx_shift ^ rx_pbit;
  // zero parity and no parity never report a parity error
  wire rx_pe = cfg.parity == PAR_EVEN ? rx_ones : // see R15
               cfg.parity == PAR_ODD ? !rx_ones : 1'b0; // see R11
  wire [7:0] rx_word = cfg.char_len_sel ? rx_shift :
                       {1'b0, rx_shift[6:0]}; // see R9
  // completion wins over a buffer read in the same clock
  wire rx_finish = rx_state == ST_STOP && rx_mid;
  wire rx_ove = rx_full && !rd_rxd;

  // clearing rx_en stops at once and leaves buffer and flags alone
  always_ff @(posedge CLK) begin
    if (SYS_RST || !cfg.rx_en) begin
      rx_state <= ST_IDLE;
      rx_ticks <= 4'h0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_pbit <= 1'b0;
    end else begin
      if (tick) begin
        rx_ticks <= rx_ticks + 4'h1;
      end
      case (rx_state)
        ST_IDLE: begin
          rx_ticks <= 4'h0;
          if (tick && !RXD) begin
            rx_shift <= 8'h00;
            rx_state <= ST_START;
          end
        end
        ST_START: begin
          // recheck half a bit on; a short glitch is dropped
          if (tick && rx_ticks == `TICK_HALF) begin
            rx_ticks <= 4'h0;
            rx_bit <= 3'h0;
            rx_state <= RXD ? ST_IDLE : ST_DATA; // see R17
          end
        end
        ST_DATA: begin
          if (rx_mid) begin
            rx_shift[rx_bit] <= RXD;
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == last_bit) begin
              rx_state <= cfg.parity == PAR_NONE ? ST_STOP : ST_PAR;
            end
          end
        end
        ST_PAR: begin
          if (rx_mid) begin
            rx_pbit <= RXD;
            rx_state <= ST_STOP;
          end
        end
        ST_STOP: begin
          // only the first stop is looked at, even with two set
          if (rx_mid) begin
            rx_state <= ST_IDLE; // see R14
          end
        end
        default: rx_state <= ST_IDLE;
      endcase
    end
  end

  // receive buffer and error cause, cleared by buffer read
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rx_data <= 8'h00;
      rx_full <= 1'b0;
      rx_error_status <= 3'h0;
      rx_done <= 1'b0;
      rx_err_ev <= 1'b0;
    end else begin
      rx_done <= rx_finish;
      rx_err_ev <= rx_finish && (rx_pe || !RXD || rx_ove);
      if (rx_finish) begin
        rx_data <= rx_word;
        rx_full <= 1'b1;
        rx_error_status <= {rx_pe, !RXD, rx_ove}; // see R12
      end else if (rd_rxd) begin
        rx_full <= 1'b0;
        rx_error_status <= 3'h0;
      end
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  logic [2:0] events;
  logic [2:0] w1c;
  always_comb begin
    events = 3'h0;
    events[`EV_TX_DONE] = tx_done;
    events[`EV_RX_DONE] = rx_done;
    events[`EV_RX_ERR] = rx_err_ev;
    w1c = wr_isr ? w_data[2:0] : 3'h0;
  end

  // a new event beats a write-one clear in the same clock
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      int_status <= `IRQ_RESET;
    end else begin
      int_status <= (int_status & ~w1c) | events;
    end
  end
  assign IRQ = |(int_status & int_mask);

endmodule
`default_nettype wire

// file: tb/uart_bf_asserts.sv
// port checker for the uart baud generator and framing block
`timescale 1ns/1ps
`default_nettype none
`include "uart_bg_params.svh"
module uart_bf_chk
  import uart_bg_pkg::*;
(
  input wire logic CLK, SYS_RST, TXD, // clock, reset, line
  input wire logic AWVALID, AWREADY, WVALID, WREADY, // write
  input wire logic BVALID, BREADY, ARVALID, ARREADY, // handshakes
  input wire logic RVALID, RREADY, // read
  input wire logic [19:0] AWADDR, ARADDR, // addresses
  input wire logic [31:0] WDATA, RDATA, // data
  input wire logic [3:0] WSTRB, // strobes
  input wire logic [1:0] BRESP, RRESP // answers
);
  // ********
  // helper logic
  // ********
  logic [3:0] code; // last selector code written
  logic [15:0] low_run; // cycles the line sat low
  wire w_go = AWVALID && AWREADY && WVALID && WREADY;
  wire ar_go = ARVALID && ARREADY;
  wire aw_map = AWADDR[19:2] inside {`IDX_CFG, `IDX_ERR,
    [`IDX_BSS:`IDX_IMR]};
  wire ar_map = ARADDR[19:2] inside {`IDX_CFG, `IDX_ERR,
    [`IDX_BSS:`IDX_IMR]};
  // start bit may gain or lose a tick to divider phase
  wire [15:0] bit_p = 16'd32 << code;
  wire [15:0] tick_p = 16'd2 << code;
  wire [15:0] rem = (low_run + tick_p) & (bit_p - 16'd1);
  // selector follows full-word writes only (all four strobes)
  always_ff @(posedge CLK) begin
    if (SYS_RST) code <= 4'h0;
    else if (w_go && AWADDR[19:2] == `IDX_BSS && WSTRB == 4'hf)
      code <= WDATA[7:4];
  end
  // length of each low run on the line
  always_ff @(posedge CLK) begin
    if (SYS_RST || TXD) low_run <= 16'h0;
    else low_run <= low_run + 16'h1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_bresp;
    !BVALID ##1 BVALID;
  endsequence
  property p_rst;
    $past(SYS_RST) |-> TXD && !BVALID && !RVALID;
  endproperty
  property p_wok;
    w_go && aw_map |=> s_bresp ##0 BRESP == `RESP_OKAY;
  endproperty
  property p_wunm;
    w_go && !aw_map |=> s_bresp ##0 BRESP == `RESP_DECERR;
  endproperty
  property p_bdone;
    BVALID && BREADY |=> !BVALID;
  endproperty
  property p_rans;
    ar_go |=> RVALID;
  endproperty
  property p_unm;
    ar_go && !ar_map |=> RRESP == `RESP_DECERR && RDATA == 32'h0;
  endproperty
  property p_bss;
    ar_go && ARADDR[19:2] == `IDX_BSS |=> RDATA[3:0] == 4'h0 &&
      RDATA[31:8] == 24'h0;
  endproperty
  property p_bit;
    $rose(TXD) && code < 4'h8 |-> rem <= 2 * tick_p;
  endproperty
  a_rst: assert property (p_rst)
    else $error("bad state after reset");
  a_wok: assert property (p_wok)
    else $error("write answer late or wrong");
  a_wunm: assert property (p_wunm)
    else $error("unmapped write not refused");
  a_bdone: assert property (p_bdone)
    else $error("write answer held too long");
  a_rans: assert property (p_rans)
    else $error("read answer late");
  a_unm: assert property (p_unm)
    else $error("unmapped read not refused");
  a_bss: assert property (p_bss)
    else $error("selector low nibble not zero");
  a_bit: assert property (p_bit)
    else $error("bit length off the selected rate");
endmodule
bind uart_baud_framing uart_bf_chk i_chk (.*);
`default_nettype wire

// file: tb/uart_remote.sv
// remote serial partner model for the uart block
`timescale 1ns/1ps
`default_nettype none
module uart_remote (
  input wire logic CLK, // system clock
  input wire logic TXD, // line from the block
  output logic RXD // line into the block
);
  initial RXD = 1'b1; // idle line is pulled high
  // ********
  // frame tasks
  // ********
  // bits go out lsb first, each held per cycles
  task automatic send(input logic [11:0] b, input int n, per);
    for (int i = 0; i < n; i++) begin
      RXD <= b[i];
      repeat (per) @(posedge CLK);
    end
    RXD <= 1'b1;
  endtask
  // sample mid bit, timed from the start edge
  task automatic recv(output logic [11:0] b, input int n, per);
    b = 12'h0;
    while (TXD !== 1'b0) @(posedge CLK);
    repeat (per / 2) @(posedge CLK);
    for (int i = 0; i < n; i++) begin
      b[i] = TXD;
      repeat (per) @(posedge CLK);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/uart_baud_framing_test.sv
// self-checking bench for the uart baud generator and framing block
`timescale 1ns/1ps
`default_nettype none
`include "uart_bg_params.svh"
module uart_baud_framing_test
  import uart_bg_pkg::*;
;
  logic CLK = 0, SYS_RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0;
  logic ARVALID = 0, RREADY = 0, EXT_BIT_CLK = 0, er;
  logic [19:0] AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0, rdv;
  logic [3:0] WSTRB = 0;
  logic [1:0] ec = 0, rsp;
  logic [11:0] fb, rb;
  logic [7:0] c, d;
  logic [7:0] sel [2] = '{8'h30, 8'h80};
  int per [2] = '{256, 96};
  wire logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TXD, RXD, IRQ;
  wire logic [1:0] BRESP, RRESP;
  wire logic [31:0] RDATA;
  int miscompares = 0, n_compared = 0, seed = 32'hf2d3, n, fi;
  uart_baud_framing i_dut (.*);
  uart_remote i_rem (.*);
  initial forever #12.5 CLK = ~CLK;
  // ext pin runs free, six clocks a period; only the bench drives it
  always @(posedge CLK) begin
    ec <= (ec == 2'd2) ? 2'd0 : ec + 2'd1;
    if (ec == 2'd2) EXT_BIT_CLK <= ~EXT_BIT_CLK;
  end
  // ********
  // tasks
  // ********
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [17:0] i, input logic [31:0] v,
      input logic [3:0] s);
    @(posedge CLK);
    AWADDR <= {i, 2'b00};
    WDATA <= v;
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    rsp = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [17:0] i);
    @(posedge CLK);
    ARADDR <= {i, 2'b00};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    rdv = RDATA;
    rsp = RRESP;
    RREADY <= 1'b0;
  endtask
  // whole frame on the line, start bit at bit 0
  function automatic logic [11:0] frame(input logic [7:0] dv, cv,
      output int nb);
    logic [11:0] b;
    logic [7:0] m;
    b = 12'hfff;
    m = dv & {cv[3], 7'h7f};
    nb = cv[3] ? 9 : 8;
    b[0] = 1'b0;
    for (int i = 0; i < nb - 1; i++) b[i + 1] = m[i];
    if (cv[5:4] != PAR_NONE) begin
      b[nb] = (cv[5:4] == PAR_ZERO) ? 1'b0 : ^m ^ (cv[5:4] == PAR_ODD);
      nb++;
    end
    nb = nb + 1 + cv[2];
    return b & ((12'h1 << nb) - 12'h1);
  endfunction
  // send d under cfg c and collect it at the partner
  task automatic xtx(input int p);
    fb = frame(d, c, n);
    fork
      i_rem.recv(rb, n, p);
      wr(`IDX_TXD, {24'h0, d}, 4'hf);
    join
    chk({20'h0, rb}, {20'h0, fb});
    do rd(`IDX_TXD); while (rdv[0] !== 1'b0);
  endtask
  task automatic close_out;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ********
  // tests
  // ********
  initial begin
    repeat (4) @(posedge CLK);
    SYS_RST <= 1'b0;
    rd(`IDX_BSS);
    chk(rdv, 32'h0);
    wr(`IDX_BSS, 32'hff, 4'hf);
    rd(`IDX_BSS);
    chk(rdv, 32'hf0);
    wr(`IDX_BSS, 32'h25, 4'h1);
    rd(`IDX_BSS);
    chk(rdv, 32'hf0);
    wr(18'h0, 32'h1, 4'hf);
    rd(18'h0);
    chk({30'h0, rsp}, {30'h0, `RESP_DECERR});
    $display("register test done");
    // fastest code allowed at this clock, set while idle
    wr(`IDX_BSS, 32'h20, 4'hf);
    for (int k = 0; k < 8; k++) begin
      c = {2'b11, k[1:0], k[2], 1'($random(seed)), 2'b00};
      d = 8'($random(seed));
      wr(`IDX_CFG, {24'h0, c}, 4'hf);
      xtx(128);
    end
    rd(`IDX_ISR);
    chk(rdv, 32'h1);
    chk({31'h0, IRQ}, 32'h0);
    wr(`IDX_ISR, 32'h7, 4'hf);
    wr(`IDX_IMR, 32'h6, 4'hf);
    $display("transmit test done");
    // upper half of the loop corrupts parity, or the stop bit
    for (int k = 0; k < 16; k++) begin
      c = {2'b11, k[1:0], k[2], 1'($random(seed)), 2'b00};
      d = 8'($random(seed));
      er = k[3];
      fi = c[3] ? 9 : 8;
      wr(`IDX_CFG, {24'h0, c}, 4'hf);
      fb = frame(d, c, n);
      fb[fi] = fb[fi] ^ er;
      i_rem.send(fb, n, 128);
      while (IRQ !== 1'b1) @(posedge CLK);
      rd(`IDX_ERR);
      chk(rdv, {29'h0, er & c[5], er & c[5:4] == 2'b00, 1'b0});
      rd(`IDX_RXD);
      chk(rdv, {24'h0, d & {c[3], 7'h7f}});
      wr(`IDX_ISR, 32'h7, 4'hf);
      chk({31'h0, IRQ}, 32'h0);
    end
    $display("receive test done");
    foreach (sel[j]) begin
      wr(`IDX_BSS, {24'h0, sel[j]}, 4'hf);
      rd(`IDX_BSS);
      chk(rdv, {24'h0, sel[j]});
      c = 8'h88;
      d = 8'($random(seed));
      wr(`IDX_CFG, 32'h88, 4'hf);
      xtx(per[j]);
    end
    $display("rate test done");
    close_out;
  end
  // nearly three times the expected run
  initial begin
    repeat (100000) @(posedge CLK);
    miscompares++;
    close_out;
  end
endmodule
`default_nettype wire
